/* logic/pwct_pkg.sv */
// Shared constants and carriers for the pulse width capture timer.
// Assumes a single system clock that serves as the main oscillator clock.
package pwct_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [15:0] PWCT_CTRL_IDX = 16'hff62;
    localparam logic [15:0] PWCT_COUNT_IDX = 16'hff63;
    localparam logic [15:0] PWCT_RISE_IDX = 16'hff64;
    localparam logic [15:0] PWCT_FALL_IDX = 16'hff65;
    localparam int PWCT_IDX_LSB = 2;
    localparam int PWCT_IDX_MSB = 17;
    localparam int PWCT_ADDR_W = 32;
    localparam int PWCT_AXI_DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // Control register layout
    localparam int PWCT_REG_W = 8;
    localparam int PWCT_RUN_BIT = 7;
    localparam int PWCT_SEL_HI_BIT = 1;
    localparam int PWCT_SEL_LO_BIT = 0;
    localparam logic [7:0] PWCT_CTRL_RESET = 8'h00;
    localparam logic [7:0] PWCT_CTRL_WMASK = 8'h83;
    localparam logic [7:0] PWCT_COUNT_RESET = 8'h00;
    localparam logic [7:0] PWCT_CAP_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Count clock division: terminal mask for each select code
    localparam int PWCT_PRESC_W = 10;
    localparam logic [1:0] PWCT_SEL_DIV1024 = 2'h0;
    localparam logic [1:0] PWCT_SEL_DIV512 = 2'h1;
    localparam logic [1:0] PWCT_SEL_DIV256 = 2'h2;
    localparam logic [1:0] PWCT_SEL_DIV128 = 2'h3;
    localparam logic [9:0] PWCT_MASK_DIV1024 = 10'h3ff;
    localparam logic [9:0] PWCT_MASK_DIV512 = 10'h1ff;
    localparam logic [9:0] PWCT_MASK_DIV256 = 10'h0ff;
    localparam logic [9:0] PWCT_MASK_DIV128 = 10'h07f;

    ////////////////////////////////////////////////////////////////////////
    // Input qualification
    localparam logic [2:0] PWCT_MIN_LEVEL_TICKS = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // AXI responses
    localparam logic [1:0] PWCT_RESP_OKAY = 2'h0;
    localparam logic [1:0] PWCT_RESP_SLVERR = 2'h2;

    // Qualified edge events, one-cycle pulses
    typedef struct packed {
        logic rise;
        logic fall;
    } pwct_edge_t;

endpackage : pwct_pkg

/* logic/pwct_prescaler.sv */
// Count clock divider for the pulse width capture timer.
// Assumes clk_i is the main clock; emits a one-cycle tick per count period.
`timescale 1ns/1ps
module pwct_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    import pwct_pkg::*;

    typedef struct packed {
        logic [PWCT_PRESC_W-1:0] div;
        logic tick;
    } pwct_presc_state_t;

    pwct_presc_state_t st;
    pwct_presc_state_t next_st;

    // Terminal mask for the selected division
    function automatic logic [PWCT_PRESC_W-1:0] pwct_div_mask(input logic [1:0] sel);
        case (sel)
            PWCT_SEL_DIV1024: pwct_div_mask = PWCT_MASK_DIV1024;
            PWCT_SEL_DIV512: pwct_div_mask = PWCT_MASK_DIV512;
            PWCT_SEL_DIV256: pwct_div_mask = PWCT_MASK_DIV256;
            default: pwct_div_mask = PWCT_MASK_DIV128;
        endcase
    endfunction : pwct_div_mask

    ////////////////////////////////////////////////////////////////////////
    // Held at zero while stopped so the first period after start is whole
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run_i) begin
            next_st.div = '0;
        end else begin
            next_st.div = st.div + 10'h001;
            next_st.tick = ((st.div & pwct_div_mask(sel_i)) == pwct_div_mask(sel_i));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

endmodule : pwct_prescaler

/* logic/pwct_edge_sampler.sv */
// Pin synchroniser and edge qualifier for the pulse width capture timer.
// Assumes pin_i is asynchronous and tick_i is a one-cycle count clock enable.
`timescale 1ns/1ps
module pwct_edge_sampler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic run_i,
    input wire logic tick_i,
    output pwct_pkg::pwct_edge_t edge_o
);
    import pwct_pkg::*;

    typedef struct packed {
        logic [2:0] sync;
        logic stable;
        logic tick_level;
        logic [2:0] run_len;
        logic phase;
        logic [1:0] samp;
        logic level;
        pwct_edge_t evt;
    } pwct_samp_state_t;

    pwct_samp_state_t st;
    pwct_samp_state_t next_st;
    logic [1:0] new_samp;
    logic [2:0] new_len;

    ////////////////////////////////////////////////////////////////////////
    // Stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
    always_comb begin
        next_st = st;
        new_samp = st.samp;
        new_len = st.run_len;
        next_st.evt = '0;
        next_st.sync = {st.sync[1:0], pin_i};
        if (st.sync[1] == st.sync[2]) begin
            next_st.stable = st.sync[2];
        end
        if (!run_i) begin
            // Stopped: forget partial history, keep the accepted level
            next_st.phase = 1'b0;
            next_st.run_len = '0;
            next_st.samp = {st.level, st.level};
            next_st.tick_level = st.level;
        end else if (tick_i) begin
            // Ticks spent at the current level, saturating at the minimum
            if (st.stable != st.tick_level) begin
                new_len = 3'h1;
            end else if (st.run_len < PWCT_MIN_LEVEL_TICKS) begin
                new_len = st.run_len + 3'h1;
            end
            next_st.run_len = new_len;
            next_st.tick_level = st.stable;
            next_st.phase = ~st.phase;
            // Sample on every second tick
            if (st.phase) begin
                new_samp = {st.samp[0], st.stable};
                next_st.samp = new_samp;
                // Two agreeing samples and a long enough level
                if (new_samp[1] == new_samp[0] && new_samp[0] != st.level
                        && new_len >= PWCT_MIN_LEVEL_TICKS) begin
                    next_st.level = new_samp[0];
                    next_st.evt.rise = new_samp[0];
                    next_st.evt.fall = ~new_samp[0];
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign edge_o = st.evt;

endmodule : pwct_edge_sampler

/* logic/pwct_top.sv */
// Pulse width capture timer: free-running 8-bit counter with rise and fall captures.
// Assumes an AXI4-Lite master on clk_i and an asynchronous pulse source on pulse_input_pin_i.
//
// How it works
// - Counter is zero after reset and whenever run enable is cleared.
// - Qualified rising edge copies counter into rise capture, held until next rise.
// - Qualified falling edge copies counter into fall capture, held until next fall.
// - Captures are read as whole 8-bit values and reset to zero.
// - Run enable low clears and halts counter; high counts each selected tick.
// - Select 00/01/10/11 divides main clock by 1024/512/256/128.
// - Control register takes byte writes and resets to zero.
// - Counter runs freely at 8 bits; width is capture difference times period.
// - Counter wraps from maximum to zero and keeps counting.
// - Input sampled every two count ticks; two matching samples needed to capture.
// - Levels shorter than five count ticks never cause a capture.
`timescale 1ns/1ps
module pwct_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // Pulse source
    input wire logic pulse_input_pin_i,
    // AXI4-Lite write address
    input wire logic [pwct_pkg::PWCT_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [pwct_pkg::PWCT_AXI_DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [pwct_pkg::PWCT_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [pwct_pkg::PWCT_AXI_DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import pwct_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Types

    // Write channel phases
    typedef enum logic [1:0] {
        PWCT_WR_COLLECT = 2'b01,
        PWCT_WR_RESP = 2'b10
    } pwct_wr_state_t;

    // Read channel phases
    typedef enum logic [1:0] {
        PWCT_RD_IDLE = 2'b01,
        PWCT_RD_DATA = 2'b10
    } pwct_rd_state_t;

    // Register select, one bit per mapped register
    typedef struct packed {
        logic ctrl;
        logic count;
        logic rise;
        logic fall;
    } pwct_sel_t;

    typedef struct packed {
        // Registers
        logic [PWCT_REG_W-1:0] ctrl;
        logic [PWCT_REG_W-1:0] count;
        logic [PWCT_REG_W-1:0] rise_cap;
        logic [PWCT_REG_W-1:0] fall_cap;
        // Write side
        pwct_wr_state_t wr_state;
        logic aw_held;
        logic w_held;
        logic [PWCT_ADDR_W-1:0] waddr;
        logic [PWCT_REG_W-1:0] wbyte;
        logic wlane0;
        logic [1:0] bresp;
        // Read side
        pwct_rd_state_t rd_state;
        logic [PWCT_AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } pwct_state_t;

    pwct_state_t st;
    pwct_state_t next_st;
    logic count_tick;
    pwct_edge_t edge_evt;
    pwct_sel_t wsel;
    pwct_sel_t rsel;
    logic run_en;
    logic [1:0] clk_sel;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Address decode; upper address bits must be zero for a hit
    function automatic pwct_sel_t pwct_decode(input logic [PWCT_ADDR_W-1:0] addr);
        logic [15:0] idx;
        logic upper_zero;
        idx = addr[PWCT_IDX_MSB:PWCT_IDX_LSB];
        upper_zero = (addr[PWCT_ADDR_W-1:PWCT_IDX_MSB+1] == '0);
        pwct_decode.ctrl = upper_zero && (idx == PWCT_CTRL_IDX);
        pwct_decode.count = upper_zero && (idx == PWCT_COUNT_IDX);
        pwct_decode.rise = upper_zero && (idx == PWCT_RISE_IDX);
        pwct_decode.fall = upper_zero && (idx == PWCT_FALL_IDX);
    endfunction : pwct_decode

    // Zero-extend an 8-bit register onto the 32-bit bus
    function automatic logic [PWCT_AXI_DATA_W-1:0] pwct_widen(input logic [PWCT_REG_W-1:0] v);
        pwct_widen = {{(PWCT_AXI_DATA_W-PWCT_REG_W){1'b0}}, v};
    endfunction : pwct_widen

    ////////////////////////////////////////////////////////////////////////
    // Control fields
    assign run_en = st.ctrl[PWCT_RUN_BIT];
    assign clk_sel = {st.ctrl[PWCT_SEL_HI_BIT], st.ctrl[PWCT_SEL_LO_BIT]};

    ////////////////////////////////////////////////////////////////////////
    // Count clock and pin qualification
    pwct_prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_en),
        .sel_i(clk_sel),
        .tick_o(count_tick)
    );

    pwct_edge_sampler u_edge_sampler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pulse_input_pin_i),
        .run_i(run_en),
        .tick_i(count_tick),
        .edge_o(edge_evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus handshakes; one write and one read in flight at most
    assign s_axi_awready_o = (st.wr_state == PWCT_WR_COLLECT) && !st.aw_held;
    assign s_axi_wready_o = (st.wr_state == PWCT_WR_COLLECT) && !st.w_held;
    assign s_axi_bvalid_o = (st.wr_state == PWCT_WR_RESP);
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_arready_o = (st.rd_state == PWCT_RD_IDLE);
    assign s_axi_rvalid_o = (st.rd_state == PWCT_RD_DATA);
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;

    assign wsel = pwct_decode(st.waddr);
    assign rsel = pwct_decode(s_axi_araddr_i);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;

        // Counter: cleared while stopped, wraps freely while running
        if (!run_en) begin
            next_st.count = PWCT_COUNT_RESET;
        end else if (count_tick) begin
            next_st.count = st.count + 8'h01;
        end

        // Captures take the live counter value and hold it otherwise
        if (edge_evt.rise) begin
            next_st.rise_cap = st.count;
        end
        if (edge_evt.fall) begin
            next_st.fall_cap = st.count;
        end

        // Address and data may arrive in either order
        case (st.wr_state)
            PWCT_WR_COLLECT: begin
                if (s_axi_awvalid_i && !st.aw_held) begin
                    next_st.aw_held = 1'b1;
                    next_st.waddr = s_axi_awaddr_i;
                end
                if (s_axi_wvalid_i && !st.w_held) begin
                    next_st.w_held = 1'b1;
                    next_st.wbyte = s_axi_wdata_i[PWCT_REG_W-1:0];
                    next_st.wlane0 = s_axi_wstrb_i[0];
                end
                // Commit one cycle after both halves are held
                if (st.aw_held && st.w_held) begin
                    next_st.aw_held = 1'b0;
                    next_st.w_held = 1'b0;
                    next_st.wr_state = PWCT_WR_RESP;
                    if (wsel.ctrl) begin
                        next_st.bresp = PWCT_RESP_OKAY;
                        // Unused bits are dropped, so stray ones never stick
                        if (st.wlane0) begin
                            next_st.ctrl = st.wbyte & PWCT_CTRL_WMASK;
                        end
                    end else begin
                        // Read-only and unmapped words refuse writes
                        next_st.bresp = PWCT_RESP_SLVERR;
                    end
                end
            end
            PWCT_WR_RESP: begin
                if (s_axi_bready_i) begin
                    next_st.wr_state = PWCT_WR_COLLECT;
                    next_st.bresp = PWCT_RESP_OKAY;
                end
            end
            default: begin
                next_st.wr_state = PWCT_WR_COLLECT;
                next_st.aw_held = 1'b0;
                next_st.w_held = 1'b0;
            end
        endcase

        // Read data is sampled at the address handshake
        case (st.rd_state)
            PWCT_RD_IDLE: begin
                if (s_axi_arvalid_i) begin
                    next_st.rd_state = PWCT_RD_DATA;
                    next_st.rresp = PWCT_RESP_OKAY;
                    if (rsel.ctrl) begin
                        next_st.rdata = pwct_widen(st.ctrl);
                    end else if (rsel.count) begin
                        next_st.rdata = pwct_widen(st.count);
                    end else if (rsel.rise) begin
                        next_st.rdata = pwct_widen(st.rise_cap);
                    end else if (rsel.fall) begin
                        next_st.rdata = pwct_widen(st.fall_cap);
                    end else begin
                        next_st.rdata = '0;
                        next_st.rresp = PWCT_RESP_SLVERR;
                    end
                end
            end
            PWCT_RD_DATA: begin
                if (s_axi_rready_i) begin
                    next_st.rd_state = PWCT_RD_IDLE;
                    next_st.rdata = '0;
                    next_st.rresp = PWCT_RESP_OKAY;
                end
            end
            default: begin
                next_st.rd_state = PWCT_RD_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st.ctrl <= PWCT_CTRL_RESET;
            st.count <= PWCT_COUNT_RESET;
            st.rise_cap <= PWCT_CAP_RESET;
            st.fall_cap <= PWCT_CAP_RESET;
            st.wr_state <= PWCT_WR_COLLECT;
            st.aw_held <= 1'b0;
            st.w_held <= 1'b0;
            st.waddr <= '0;
            st.wbyte <= '0;
            st.wlane0 <= 1'b0;
            st.bresp <= PWCT_RESP_OKAY;
            st.rd_state <= PWCT_RD_IDLE;
            st.rdata <= '0;
            st.rresp <= PWCT_RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

endmodule : pwct_top

/* sim/pwct_pulse_src.sv */
// Behavioural pulse source standing on the timer's input pin.
// Assumes widths are given in system clocks; pin idles low when disabled.
`timescale 1ns/1ps
module pwct_pulse_src (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic [15:0] hi_cycles_i,
    input wire logic [15:0] lo_cycles_i,
    output logic pin_o
);
    initial pin_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // One high then one low level per pass; each width latched as its level starts
    always begin
        if (en_i) begin
            pin_o <= 1'b1;
            repeat (hi_cycles_i) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (lo_cycles_i) @(posedge clk_i);
        end else @(posedge clk_i);
    end
endmodule : pwct_pulse_src

/* sim/pwct_checker.sv */
// Bus and timing assertions for the pulse width capture timer.
// Assumes it sees only the top ports, attached by the bind below.
`timescale 1ns/1ps
module pwct_checker
    import pwct_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    // Handshake events
    sequence s_ar_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    sequence s_w_both;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence

    property p_read_lat;
        s_ar_taken |=> s_axi_rvalid_o;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data late");
    property p_read_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data dropped");
    property p_rdata_byte;
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000;
    endproperty
    a_rdata_byte: assert property (p_rdata_byte) else $error("upper read bits set");
    property p_ctrl_free_bits;
        s_ar_taken and (s_axi_araddr_i[17:2] == PWCT_CTRL_IDX) |=> s_axi_rdata_o[6:2] == 5'h00;
    endproperty
    a_ctrl_free_bits: assert property (p_ctrl_free_bits) else $error("free control bits set");
    property p_unmapped_rd;
        s_ar_taken and (s_axi_araddr_i[31:18] != 14'h0000)
            |=> s_axi_rresp_o == PWCT_RESP_SLVERR && s_axi_rdata_o == 32'h00000000;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read answered");
    property p_write_lat;
        s_w_both |-> !s_axi_bvalid_o ##1 !s_axi_bvalid_o ##1 s_axi_bvalid_o;
    endproperty
    a_write_lat: assert property (p_write_lat) else $error("write response timing");
    property p_write_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write response dropped");
    property p_busy_block;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("write taken while busy");
    property p_ar_block;
        s_axi_rvalid_o |-> !s_axi_arready_o;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule : pwct_checker

bind pwct_top pwct_checker pwct_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i)
);

/* sim/pulse_width_capture_timer_tb_top.sv */
// Self-checking bench for the pulse width capture timer.
// Assumes AXI4-Lite register access and the behavioural pulse source.
`timescale 1ns/1ps
module pulse_width_capture_timer_tb_top;
    import pwct_pkg::*;
    localparam int TK = 128;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd, r0, f0, r1, f1;
    logic [3:0] wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pin, src_en = 0;
    logic [1:0] bresp, rresp;
    logic [15:0] hi_c = 16'h0001, lo_c = 16'h0001;
    int num_errors = 0;
    int checks = 0;

    always #4 clk_i = ~clk_i;

    pwct_top pwct_top_i (.clk_i(clk_i), .rst_i(rst_i), .pulse_input_pin_i(pin),
        .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));
    pwct_pulse_src pwct_pulse_src_i (.clk_i(clk_i), .en_i(src_en), .hi_cycles_i(hi_c),
        .lo_cycles_i(lo_c), .pin_o(pin));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison helpers
    task results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check

    task timed_out(input string name);
        $display("CHECK FAILED %s expected answer seen timeout", name);
        num_errors++;
        results();
    endtask : timed_out

    function automatic logic [31:0] addr_of(input logic [15:0] idx);
        return {14'h0000, idx, 2'h0};
    endfunction : addr_of

    ////////////////////////////////////////////////////////////////////////
    // Bus tasks: ready sampled mid-cycle, so it is the value seen at the next edge
    task automatic axi_write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
            input logic [1:0] exp);
        logic ta, tw, tb;
        logic [1:0] resp;
        @(posedge clk_i);
        awaddr <= a; wdata <= {24'h000000, d}; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        tb = 1'b0;
        for (int n = 0; n < 100 && !tb; n++) begin
            @(negedge clk_i);
            ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; resp = bresp;
            @(posedge clk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
        if (!tb) timed_out("bvalid");
        check("bresp", {30'h0, exp}, {30'h0, resp});
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, input logic [1:0] exp, output logic [31:0] d);
        logic ta, tr;
        logic [1:0] resp;
        @(posedge clk_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        tr = 1'b0;
        for (int n = 0; n < 100 && !tr; n++) begin
            @(negedge clk_i);
            ta = arvalid && arready; tr = rvalid; d = rdata; resp = rresp;
            @(posedge clk_i);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
        if (!tr) timed_out("rvalid");
        check("rresp", {30'h0, exp}, {30'h0, resp});
    endtask : axi_read

    task automatic wait_pin(input logic lvl);
        int n;
        for (n = 0; n < 20000 && pin !== lvl; n++) @(posedge clk_i);
        if (n == 20000) timed_out("pin level");
    endtask : wait_pin

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values of all four registers
        for (int i = 0; i < 4; i++) begin
            axi_read(addr_of(PWCT_CTRL_IDX + 16'(i)), PWCT_RESP_OKAY, rd);
            check("reset value", 32'h0, rd);
        end
        // Control write, masked write, read-only and unmapped places
        axi_write(addr_of(PWCT_CTRL_IDX), 8'h83, 4'h1, PWCT_RESP_OKAY);
        axi_write(addr_of(PWCT_CTRL_IDX), 8'h00, 4'h0, PWCT_RESP_OKAY);
        axi_read(addr_of(PWCT_CTRL_IDX), PWCT_RESP_OKAY, rd);
        check("control", 32'h83, rd);
        axi_write(addr_of(PWCT_RISE_IDX), 8'h55, 4'h1, PWCT_RESP_SLVERR);
        axi_write(32'h00040000, 8'h01, 4'h1, PWCT_RESP_SLVERR);
        axi_read(32'h00040000, PWCT_RESP_SLVERR, rd);
        check("unmapped", 32'h0, rd);
        // Stop clears the counter; each select divides by its figure
        for (int s = 0; s < 4; s++) begin
            axi_write(addr_of(PWCT_CTRL_IDX), 8'h00, 4'h1, PWCT_RESP_OKAY);
            axi_read(addr_of(PWCT_COUNT_IDX), PWCT_RESP_OKAY, rd);
            check("stopped count", 32'h0, rd);
            axi_write(addr_of(PWCT_CTRL_IDX), 8'h80 | 8'(s), 4'h1, PWCT_RESP_OKAY);
            repeat (5 << (9 - s)) @(posedge clk_i);
            axi_read(addr_of(PWCT_COUNT_IDX), PWCT_RESP_OKAY, rd);
            check("count after 2.5 periods", 32'h2, rd);
        end
        // Even widths keep both edges in one sample phase, so differences are exact
        hi_c <= 16'(20 * TK);
        lo_c <= 16'(30 * TK);
        src_en <= 1'b1;
        wait_pin(1'b1);
        wait_pin(1'b0);
        repeat (12 * TK) @(posedge clk_i);
        axi_read(addr_of(PWCT_RISE_IDX), PWCT_RESP_OKAY, r0);
        axi_read(addr_of(PWCT_FALL_IDX), PWCT_RESP_OKAY, f0);
        check("high width", 32'd20, (f0 - r0) & 32'hff);
        // Six periods of 50 ticks carry the counter past its top
        for (int p = 0; p < 6; p++) begin
            wait_pin(1'b1);
            wait_pin(1'b0);
            repeat (12 * TK) @(posedge clk_i);
            axi_read(addr_of(PWCT_RISE_IDX), PWCT_RESP_OKAY, r1);
            axi_read(addr_of(PWCT_FALL_IDX), PWCT_RESP_OKAY, f1);
            check("rise period", 32'd50, (r1 - r0) & 32'hff);
            check("fall period", 32'd50, (f1 - f0) & 32'hff);
            r0 = r1;
            f0 = f1;
        end
        // Three-tick glitch must not capture
        src_en <= 1'b0;
        repeat (40 * TK) @(posedge clk_i);
        hi_c <= 16'(3 * TK);
        lo_c <= 16'(40 * TK);
        src_en <= 1'b1;
        wait_pin(1'b1);
        src_en <= 1'b0;
        repeat (50 * TK) @(posedge clk_i);
        axi_read(addr_of(PWCT_RISE_IDX), PWCT_RESP_OKAY, r1);
        axi_read(addr_of(PWCT_FALL_IDX), PWCT_RESP_OKAY, f1);
        check("glitch rise", r0, r1);
        check("glitch fall", f0, f1);
        results();
    end
endmodule : pulse_width_capture_timer_tb_top
